// ===== ilb_defines.svh
`ifndef ILB_DEFINES_SVH
`define ILB_DEFINES_SVH

// opcode patterns and masks
`define ILB_OPC_LOOP_REG 8'hd8
`define ILB_MSK_LOOP_REG 8'hf8
`define ILB_OPC_LOOP_DIR 8'hd5
`define ILB_OPC_INC_ACC 8'h04
`define ILB_OPC_INC_DIR 8'h05
`define ILB_OPC_INC_REG 8'h08
`define ILB_MSK_INC_REG 8'hf8
`define ILB_OPC_INC_IND 8'h06
`define ILB_MSK_INC_IND 8'hfe
`define ILB_OPC_INC_PTR16 8'ha3
`define ILB_OPC_JBIT 8'h20

// instruction lengths in bytes
`define ILB_LEN_1 16'h0001
`define ILB_LEN_2 16'h0002
`define ILB_LEN_3 16'h0003

// machine cycles per instruction
`define ILB_MC_1 2'h1
`define ILB_MC_2 2'h2

// core clocks per machine cycle
`define ILB_CLKS_PER_MC 2

// reset values
`define ILB_RST_BYTE 8'h00
`define ILB_RST_WORD 16'h0000

`endif

// ===== ilb_pkg.sv
`default_nettype none

package ilb_pkg;

  // decoded instruction class
  typedef enum logic [3:0] {
    ILB_OP_NONE = 4'h0,
    ILB_OP_LOOP_R = 4'h1,
    ILB_OP_LOOP_D = 4'h2,
    ILB_OP_INC_A = 4'h3,
    ILB_OP_INC_R = 4'h4,
    ILB_OP_INC_D = 4'h5,
    ILB_OP_INC_I = 4'h6,
    ILB_OP_INC_DP = 4'h7,
    ILB_OP_JBIT = 4'h8
  } ilb_op_type;

  // destination of the write-back
  typedef enum logic [2:0] {
    ILB_DST_NONE = 3'h0,
    ILB_DST_ACC = 3'h1,
    ILB_DST_WREG = 3'h2,
    ILB_DST_DIRECT = 3'h3,
    ILB_DST_INDIRECT = 3'h4,
    ILB_DST_PTR16 = 3'h5
  } ilb_dst_type;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ILB_ST_IDLE = 2'b01,
    ILB_ST_EXEC = 2'b10
  } ilb_state_type;

endpackage

`default_nettype wire

// ===== ilb_exec.sv
// Function
// RULE_01: register loop-decrement: pc+2, decrement register, branch if result nonzero.
// RULE_02: register loop-decrement opcode 11011rrr, displacement in byte two, two cycles.
// RULE_03: direct loop-decrement: decrement byte, branch if nonzero, three bytes, two cycles.
// RULE_04: direct loop-decrement opcode 11010101, address byte two, displacement byte three.
// RULE_05: every 8-bit increment wraps ff to 00 and leaves flags alone.
// RULE_06: increment of a port takes the operand from the output latch.
// RULE_07: increment acc 00000100, register 00001rrr, indirect 0000011i; one byte, one cycle.
// RULE_08: direct increment opcode 00000101 plus address; two bytes, one cycle.
// RULE_09: pointer increment 10100011 adds one modulo 65536, one byte, two cycles.
// RULE_10: bit jump: pc+3, branch only if bit set, bit and flags untouched.
// RULE_11: bit jump opcode 00100000, bit address byte two, displacement byte three.
// RULE_12: branch target is displacement added to pc past the whole instruction.
// RULE_13: loop decrement wraps 00 to ff, no flags, port operand from latch.
// RULE_14: displacement sign-extended, target addition modulo 65536.
`timescale 1ns/1ps
`default_nettype none
`include "ilb_defines.svh"

module ilb_exec
  import ilb_pkg::*;
#(
  parameter int CLKS_PER_MC = `ILB_CLKS_PER_MC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] wreg_in,
  input wire logic [7:0] direct_in,
  input wire logic [7:0] indirect_in,
  input wire logic bit_in,
  input wire logic [15:0] data_pointer16_in,
  output logic busy_q,
  output logic done_q,
  output logic illegal_q,
  output logic branch_q,
  output logic [15:0] pc_next_q,
  output logic wr_en_q,
  output ilb_dst_type wr_dst_q,
  output logic [7:0] wr_addr_q,
  output logic [7:0] wr_data_q,
  output logic [15:0] data_pointer16_q,
  output logic latch_src_q
);

  localparam int CNT_W = 8;

  ilb_state_type state_q, state_d;
  ilb_op_type op_q, op_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0] pc_base_q, pc_base_d;
  logic busy_d, done_d, illegal_d, branch_d, wr_en_d, latch_src_d;
  logic [15:0] pc_next_d, ptr16_d;
  ilb_dst_type wr_dst_d;
  logic [7:0] wr_addr_d, wr_data_d;

  // decode stage, combinational on the offered opcode
  ilb_op_type dec_op;
  logic [15:0] dec_len;
  logic [1:0] dec_mc;

  always_comb begin
    dec_op = ILB_OP_NONE;
    dec_len = `ILB_LEN_1;
    dec_mc = `ILB_MC_1;
    // RULE_02: register loop decode
    if ((opcode & `ILB_MSK_LOOP_REG) == `ILB_OPC_LOOP_REG) begin
      dec_op = ILB_OP_LOOP_R;
      dec_len = `ILB_LEN_2;
      dec_mc = `ILB_MC_2;
    // RULE_04: direct loop decode
    end else if (opcode == `ILB_OPC_LOOP_DIR) begin
      dec_op = ILB_OP_LOOP_D;
      dec_len = `ILB_LEN_3;
      dec_mc = `ILB_MC_2;
    // RULE_07: single byte increments
    end else if (opcode == `ILB_OPC_INC_ACC) begin
      dec_op = ILB_OP_INC_A;
    end else if ((opcode & `ILB_MSK_INC_REG) == `ILB_OPC_INC_REG) begin
      dec_op = ILB_OP_INC_R;
    end else if ((opcode & `ILB_MSK_INC_IND) == `ILB_OPC_INC_IND) begin
      dec_op = ILB_OP_INC_I;
    // RULE_08: direct increment decode
    end else if (opcode == `ILB_OPC_INC_DIR) begin
      dec_op = ILB_OP_INC_D;
      dec_len = `ILB_LEN_2;
    // RULE_09: pointer increment decode
    end else if (opcode == `ILB_OPC_INC_PTR16) begin
      dec_op = ILB_OP_INC_DP;
      dec_mc = `ILB_MC_2;
    // RULE_11: bit jump decode
    end else if (opcode == `ILB_OPC_JBIT) begin
      dec_op = ILB_OP_JBIT;
      dec_len = `ILB_LEN_3;
      dec_mc = `ILB_MC_2;
    end
  end

  // arithmetic; all 8-bit results wrap, no flag path exists
  logic [15:0] pc_seq, rel_ext, pc_tgt;
  logic [7:0] rel_byte, dec_r, dec_d;
  logic [15:0] ptr16_inc;

  always_comb begin
    // RULE_12: sequential pc past the whole instruction
    pc_seq = pc_in + dec_len;
    rel_byte = (dec_op == ILB_OP_LOOP_R) ? byte2 : byte3;
    // RULE_14: sign extension, 16-bit wrap
    rel_ext = {{8{rel_byte[7]}}, rel_byte};
    pc_tgt = pc_seq + rel_ext;
    // RULE_13: decrement wraps 00 to ff
    dec_r = wreg_in - 8'h01;
    dec_d = direct_in - 8'h01;
    // RULE_09: carry ripples into the high byte
    ptr16_inc = data_pointer16_in + 16'h0001;
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    pc_base_d = pc_base_q;
    busy_d = busy_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    branch_d = branch_q;
    pc_next_d = pc_next_q;
    wr_en_d = wr_en_q;
    wr_dst_d = wr_dst_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    ptr16_d = data_pointer16_q;
    latch_src_d = latch_src_q;
    case (state_q)
      ILB_ST_IDLE: begin
        wr_en_d = 1'b0;
        if (start && dec_op == ILB_OP_NONE) begin
          // foreign opcodes are refused at once
          illegal_d = 1'b1;
        end else if (start) begin
          state_d = ILB_ST_EXEC;
          op_d = dec_op;
          pc_base_d = pc_in;
          busy_d = 1'b1;
          cnt_d = CNT_W'(int'(dec_mc) * CLKS_PER_MC - 1);
          branch_d = 1'b0;
          pc_next_d = pc_seq;
          wr_en_d = 1'b1;
          wr_addr_d = 8'h00;
          wr_dst_d = ILB_DST_NONE;
          wr_data_d = 8'h00;
          latch_src_d = 1'b0;
          case (dec_op)
            ILB_OP_LOOP_R: begin
              // RULE_01: register decrement and test
              wr_dst_d = ILB_DST_WREG;
              wr_addr_d = {5'h00, opcode[2:0]};
              wr_data_d = dec_r;
              branch_d = (dec_r != 8'h00);
              pc_next_d = (dec_r != 8'h00) ? pc_tgt : pc_seq;
            end
            ILB_OP_LOOP_D: begin
              // RULE_03: direct decrement and test
              wr_dst_d = ILB_DST_DIRECT;
              wr_addr_d = byte2;
              wr_data_d = dec_d;
              // RULE_13: port operand from latch
              latch_src_d = 1'b1;
              branch_d = (dec_d != 8'h00);
              pc_next_d = (dec_d != 8'h00) ? pc_tgt : pc_seq;
            end
            ILB_OP_INC_A: begin
              // RULE_05: wrap ff to 00
              wr_dst_d = ILB_DST_ACC;
              wr_data_d = acc_in + 8'h01;
            end
            ILB_OP_INC_R: begin
              wr_dst_d = ILB_DST_WREG;
              wr_addr_d = {5'h00, opcode[2:0]};
              wr_data_d = wreg_in + 8'h01;
            end
            ILB_OP_INC_D: begin
              wr_dst_d = ILB_DST_DIRECT;
              wr_addr_d = byte2;
              wr_data_d = direct_in + 8'h01;
              // RULE_06: read port latch
              latch_src_d = 1'b1;
            end
            ILB_OP_INC_I: begin
              wr_dst_d = ILB_DST_INDIRECT;
              wr_addr_d = {7'h00, opcode[0]};
              wr_data_d = indirect_in + 8'h01;
            end
            ILB_OP_INC_DP: begin
              wr_dst_d = ILB_DST_PTR16;
              ptr16_d = ptr16_inc;
            end
            ILB_OP_JBIT: begin
              // RULE_10: test only, no write-back
              wr_en_d = 1'b0;
              wr_addr_d = byte2;
              branch_d = bit_in;
              pc_next_d = bit_in ? pc_tgt : pc_seq;
            end
            default: begin
              wr_en_d = 1'b0;
            end
          endcase
        end
      end
      ILB_ST_EXEC: begin
        // write strobe lasts one clock; results held until next start
        wr_en_d = 1'b0;
        if (cnt_q == '0) begin
          state_d = ILB_ST_IDLE;
          busy_d = 1'b0;
          done_d = 1'b1;
          latch_src_d = 1'b0;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = ILB_ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // registers; ce low freezes everything
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ILB_ST_IDLE;
      op_q <= ILB_OP_NONE;
      cnt_q <= '0;
      pc_base_q <= `ILB_RST_WORD;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      branch_q <= 1'b0;
      pc_next_q <= `ILB_RST_WORD;
      wr_en_q <= 1'b0;
      wr_dst_q <= ILB_DST_NONE;
      wr_addr_q <= `ILB_RST_BYTE;
      wr_data_q <= `ILB_RST_BYTE;
      data_pointer16_q <= `ILB_RST_WORD;
      latch_src_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      pc_base_q <= pc_base_d;
      busy_q <= busy_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
      branch_q <= branch_d;
      pc_next_q <= pc_next_d;
      wr_en_q <= wr_en_d;
      wr_dst_q <= wr_dst_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      data_pointer16_q <= ptr16_d;
      latch_src_q <= latch_src_d;
    end
  end

  // helper: enabled clocks spent busy, for length checks
  logic [CNT_W-1:0] run_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_q <= '0;
    end else if (ce) begin
      run_q <= busy_q ? run_q + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_loop_r_len;
    done_q && op_q == ILB_OP_LOOP_R && !branch_q |-> pc_next_q == pc_base_q + 16'h0002;
  endproperty
  a_loop_r_len: assert property (p_loop_r_len) else $error("register loop pc wrong"); // RULE_01
  property p_two_mc;
    done_q && op_q inside {ILB_OP_LOOP_R, ILB_OP_LOOP_D, ILB_OP_INC_DP, ILB_OP_JBIT}
      |-> int'(run_q) == 2 * CLKS_PER_MC;
  endproperty
  a_two_mc: assert property (p_two_mc) else $error("two cycle length wrong"); // RULE_02
  property p_loop_d_len;
    done_q && op_q == ILB_OP_LOOP_D && !branch_q |-> pc_next_q == pc_base_q + 16'h0003;
  endproperty
  a_loop_d_len: assert property (p_loop_d_len) else $error("direct loop pc wrong"); // RULE_03
  property p_loop_test;
    done_q && op_q inside {ILB_OP_LOOP_R, ILB_OP_LOOP_D} |-> branch_q == (wr_data_q != 8'h00);
  endproperty
  a_loop_test: assert property (p_loop_test) else $error("loop branch test wrong"); // RULE_13
  property p_one_mc;
    done_q && op_q inside {ILB_OP_INC_A, ILB_OP_INC_R, ILB_OP_INC_D, ILB_OP_INC_I}
      |-> int'(run_q) == CLKS_PER_MC;
  endproperty
  a_one_mc: assert property (p_one_mc) else $error("one cycle length wrong"); // RULE_07
  property p_inc_wrap;
    ce && state_q == ILB_ST_IDLE && start && opcode == `ILB_OPC_INC_ACC && acc_in == 8'hff
      |=> wr_en_q && wr_data_q == 8'h00 && wr_dst_q == ILB_DST_ACC;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong"); // RULE_05
  property p_latch_src;
    busy_q && op_q inside {ILB_OP_INC_D, ILB_OP_LOOP_D} |-> latch_src_q;
  endproperty
  a_latch_src: assert property (p_latch_src) else $error("latch source missing"); // RULE_06
  property p_ptr16;
    ce && state_q == ILB_ST_IDLE && start && opcode == `ILB_OPC_INC_PTR16
      |=> data_pointer16_q == $past(data_pointer16_in) + 16'h0001;
  endproperty
  a_ptr16: assert property (p_ptr16) else $error("pointer increment wrong"); // RULE_09
  property p_jbit_nowrite;
    busy_q && op_q == ILB_OP_JBIT |-> !wr_en_q;
  endproperty
  a_jbit_nowrite: assert property (p_jbit_nowrite) else $error("bit jump wrote"); // RULE_10
  property p_target;
    ce && state_q == ILB_ST_IDLE && start && opcode == `ILB_OPC_JBIT && bit_in
      |=> pc_next_q == $past(pc_in) + 16'h0003 + {{8{$past(byte3[7])}}, $past(byte3)};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong"); // RULE_12

  c_loop_taken: cover property (done_q && op_q == ILB_OP_LOOP_R && branch_q);
  c_bit_jump: cover property (done_q && op_q == ILB_OP_JBIT && branch_q);
  c_ptr16: cover property (done_q && op_q == ILB_OP_INC_DP);
  c_illegal: cover property (illegal_q);
endmodule // ilb_exec

`default_nettype wire

// ===== incr_loop_bit_branch_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module incr_loop_bit_branch_exec_bench import ilb_pkg::*; ;
  localparam int CPM = 2;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic bit_in = 1'b0;
  logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00;
  logic [7:0] acc_in = 8'h00, wreg_in = 8'h00, direct_in = 8'h00, indirect_in = 8'h00;
  logic [15:0] pc_in = 16'h0000, data_pointer16_in = 16'h0000;
  logic busy_q, done_q, illegal_q, branch_q, wr_en_q, latch_src_q;
  logic [15:0] pc_next_q, data_pointer16_q;
  logic [7:0] wr_addr_q, wr_data_q;
  ilb_dst_type wr_dst_q;
  int n_fail = 0;
  int samples_checked = 0;

  ilb_exec #(.CLKS_PER_MC(CPM)) i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .start(start),
    .opcode(opcode), .byte2(byte2), .byte3(byte3), .pc_in(pc_in), .acc_in(acc_in),
    .wreg_in(wreg_in), .direct_in(direct_in), .indirect_in(indirect_in), .bit_in(bit_in),
    .data_pointer16_in(data_pointer16_in), .busy_q(busy_q), .done_q(done_q),
    .illegal_q(illegal_q),
    .branch_q(branch_q), .pc_next_q(pc_next_q), .wr_en_q(wr_en_q), .wr_dst_q(wr_dst_q),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .data_pointer16_q(data_pointer16_q),
    .latch_src_q(latch_src_q));

  // 50 mhz core clock
  always #10 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one instruction; hold freezes ce mid-run, then a start while busy must be refused
  task automatic run(input logic [7:0] op, b2, b3, input logic [15:0] pc, input logic wr,
                     input logic br, input logic [15:0] pcn, input int mc, input logic lat,
                     input int hold);
    int n;
    @(posedge core_clk);
    #1;
    start = 1'b1;
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    pc_in = pc;
    @(posedge core_clk);
    #1;
    // start stays up only when a refused request is to follow
    start = (hold > 0);
    chk("busy", busy_q, 1'b1);
    chk("wr_en", wr_en_q, wr);
    chk("branch", branch_q, br);
    chk("pc_next", pc_next_q, pcn);
    chk("latch_src", latch_src_q, lat);
    // frozen clocks do not count; the extra start, an acc increment (04), meets one enabled busy edge
    if (hold > 0) begin
      ce = 1'b0;
      opcode = 8'h04;
      pc_in = 16'h5555;
    end
    repeat (hold) begin
      @(posedge core_clk);
      #1;
    end
    ce = 1'b1;
    n = 0;
    while (done_q !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
      start = 1'b0;
    end
    chk("cycles", n[15:0], 16'(mc * CPM));
    chk("pc_hold", pc_next_q, pcn);
  endtask

  task automatic t_inc;
    acc_in = 8'hff;
    run(8'h04, 8'h00, 8'h00, 16'h0100, 1'b1, 1'b0, 16'h0101, 1, 1'b0, 0);
    chk("acc_dst", wr_dst_q, ILB_DST_ACC);
    chk("acc_data", wr_data_q, 8'h00);
    wreg_in = 8'h7e;
    for (int r = 0; r < 8; r++) begin
      run(8'h08 | 8'(r), 8'h00, 8'h00, 16'hffff, 1'b1, 1'b0, 16'h0000, 1, 1'b0, 0);
      chk("reg_addr", wr_addr_q, 8'(r));
      chk("reg_data", wr_data_q, 8'h7f);
    end
    indirect_in = 8'h40;
    for (int i = 0; i < 2; i++) begin
      run(8'h06 | 8'(i), 8'h00, 8'h00, 16'h0200, 1'b1, 1'b0, 16'h0201, 1, 1'b0, 0);
      chk("ind_dst", wr_dst_q, ILB_DST_INDIRECT);
      chk("ind_addr", wr_addr_q, 8'(i));
      chk("ind_data", wr_data_q, 8'h41);
    end
    direct_in = 8'h90;
    run(8'h05, 8'h90, 8'h00, 16'h0300, 1'b1, 1'b0, 16'h0302, 1, 1'b1, 0);
    chk("dir_addr", wr_addr_q, 8'h90);
    chk("dir_data", wr_data_q, 8'h91);
  endtask

  task automatic t_loop;
    wreg_in = 8'h01;
    run(8'hdb, 8'h10, 8'h00, 16'h0400, 1'b1, 1'b0, 16'h0402, 2, 1'b0, 0);
    chk("lr_addr", wr_addr_q, 8'h03);
    chk("lr_data", wr_data_q, 8'h00);
    wreg_in = 8'h00;
    run(8'hdf, 8'h80, 8'h00, 16'h0010, 1'b1, 1'b1, 16'hff92, 2, 1'b0, 2);
    chk("lr_wrap", wr_data_q, 8'hff);
    chk("lr_dst", wr_dst_q, ILB_DST_WREG);
    direct_in = 8'h70;
    run(8'hd5, 8'h50, 8'h05, 16'hfffe, 1'b1, 1'b1, 16'h0006, 2, 1'b1, 0);
    chk("ld_addr", wr_addr_q, 8'h50);
    chk("ld_data", wr_data_q, 8'h6f);
    chk("ld_dst", wr_dst_q, ILB_DST_DIRECT);
  endtask

  task automatic t_ptr_bit;
    data_pointer16_in = 16'h12ff;
    run(8'ha3, 8'h00, 8'h00, 16'h0500, 1'b1, 1'b0, 16'h0501, 2, 1'b0, 0);
    chk("ptr16", data_pointer16_q, 16'h1300);
    chk("ptr16_dst", wr_dst_q, ILB_DST_PTR16);
    data_pointer16_in = 16'hffff;
    run(8'ha3, 8'h00, 8'h00, 16'h0501, 1'b1, 1'b0, 16'h0502, 2, 1'b0, 0);
    chk("ptr16_wrap", data_pointer16_q, 16'h0000);
    bit_in = 1'b1;
    run(8'h20, 8'h2a, 8'hfd, 16'h0100, 1'b0, 1'b1, 16'h0100, 2, 1'b0, 0);
    chk("bit_addr", wr_addr_q, 8'h2a);
    chk("bit_dst", wr_dst_q, ILB_DST_NONE);
    bit_in = 1'b0;
    run(8'h20, 8'h2b, 8'h7f, 16'h0100, 1'b0, 1'b0, 16'h0103, 2, 1'b0, 0);
    chk("ptr16_kept", data_pointer16_q, 16'h0000);
  endtask

  task automatic t_illegal;
    // opcodes outside the group are flagged, not run
    @(posedge core_clk);
    #1;
    start = 1'b1;
    opcode = 8'h15;
    @(posedge core_clk);
    #1;
    start = 1'b0;
    chk("illegal", illegal_q, 1'b1);
    chk("ill_busy", busy_q, 1'b0);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // bound well above the expected hundred or so cycles
  initial begin
    #40000;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    chk("rst_busy", busy_q, 1'b0);
    chk("rst_dst", wr_dst_q, ILB_DST_NONE);
    rst = 1'b0;
    t_inc();
    t_loop();
    t_ptr_bit();
    t_illegal();
    conclude();
  end
endmodule // incr_loop_bit_branch_exec_bench

`default_nettype wire
